// >>> src/fsps_cfg.svh
// Purpose: Constants for the flash self-program sequencer
// Assumes: 20 MHz core clock, APB with 32-bit data
// Notes: Register indices; byte address is index times four
`ifndef FSPS_CFG_SVH
`define FSPS_CFG_SVH
`define FSPS_CTRL_IDX 8'h37
`define FSPS_PTR_IDX 8'h38
`define FSPS_DATA_IDX 8'h39
`define FSPS_STAT_IDX 8'h3A
`define FSPS_CTRL_RST 5'h00
`define FSPS_CMD_LOAD 3'h1
`define FSPS_CMD_ERASE 3'h3
`define FSPS_CMD_WRITE 3'h5
`define FSPS_SPM_WIN 3'h4
`define FSPS_LPM_WIN 3'h3
`define FSPS_BLANK_WORD 16'hFFFF
`define FSPS_CLK_NS 50
`define FSPS_OP_MIN_NS 3700000
`define FSPS_OP_MAX_NS 4500000
`endif

// >>> src/fsps_pkg.sv
// Purpose: Types for the flash self-program sequencer
// Assumes: Nothing beyond the cfg header
// Notes: Control bits travel as one packed struct
package fsps_pkg;
  typedef enum logic [2:0] {
    FSPS_IDLE = 3'b001,
    FSPS_ERASE = 3'b010,
    FSPS_WRITE = 3'b100
  } fsps_state_type;

  typedef struct packed {
    logic clear_buffer_bit;
    logic fuse_lock_read_bit;
    logic page_write_bit;
    logic page_erase_bit;
    logic store_enable_bit;
  } fsps_ctrl_type;

  typedef struct packed {
    logic erase;
    logic write;
    logic [15:0] page;
  } fsps_flash_type;
endpackage

// >>> src/fsps_sequencer.sv
// Purpose: Flash self-program sequencer with APB registers
// Assumes: CPU strobes are on core_clk; fuse strap is a pin
// Notes: Flash macro reads the page buffer through buf_rd port
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "fsps_cfg.svh"
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int WORD_BITS = 5,
  parameter int OP_CYCLES =
    (`FSPS_OP_MIN_NS + `FSPS_CLK_NS - 1) / `FSPS_CLK_NS
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic store_program_instruction,
  input wire logic load_program_instruction,
  input wire logic [15:0] lpm_flash_word,
  input wire logic [31:0] fuse_lock_bytes,
  output logic [7:0] lpm_data,
  input wire logic self_program_fuse_n,
  input wire logic eeprom_write_busy_flag,
  input wire logic eeprom_write_start,
  output logic cpu_halt,
  output fsps_flash_type flash_cmd,
  input wire logic [WORD_BITS-1:0] buf_rd_addr,
  output logic [15:0] buf_rd_data
);
  localparam int WORDS = 1 << WORD_BITS;

  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  fsps_state_type state_reg, state_next;
  fsps_ctrl_type ctrl_reg, ctrl_next;
  fsps_flash_type flash_reg, flash_next;
  logic [15:0] ptr_reg, ptr_next;
  logic [15:0] data_reg, data_next;
  logic [2:0] spm_win_reg, spm_win_next;
  logic [2:0] lpm_win_reg, lpm_win_next;
  logic [16:0] op_cnt_reg, op_cnt_next;
  logic [WORDS-1:0] valid_reg, valid_next;
  logic [7:0] lpm_reg, lpm_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [15:0] buf_mem [WORDS];
  logic fuse_s1_reg, fuse_s2_reg;

  logic wr_acc, setup, hit_ctrl, hit_ptr, hit_data, hit_stat;
  logic spm_ok, op_done, fuse_rd_ok, load_ok;
  logic [2:0] cmd;
  logic [WORD_BITS-1:0] word_idx;
  logic [15:0] page_idx;

  // Strap comes from a pin, so it is synchronised first
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fuse_s1_reg <= 1'b1;
      fuse_s2_reg <= 1'b1;
    end
    else
    begin
      fuse_s1_reg <= self_program_fuse_n;
      fuse_s2_reg <= fuse_s1_reg;
    end
  end

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign hit_ctrl = paddr == byte_addr(`FSPS_CTRL_IDX);
  assign hit_ptr = paddr == byte_addr(`FSPS_PTR_IDX);
  assign hit_data = paddr == byte_addr(`FSPS_DATA_IDX);
  assign hit_stat = paddr == byte_addr(`FSPS_STAT_IDX);
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
    !(hit_ctrl || hit_ptr || hit_data || hit_stat);

  assign word_idx = ptr_reg[WORD_BITS:1];
  assign page_idx = 16'(ptr_reg >> (WORD_BITS + 1));
  assign cmd = {ctrl_reg.page_write_bit, ctrl_reg.page_erase_bit,
    ctrl_reg.store_enable_bit};
  // Strap low means programmed; EEPROM busy blocks all stores
  assign spm_ok = store_program_instruction && spm_win_reg != 3'h0
    && !fuse_s2_reg && !eeprom_write_busy_flag
    && state_reg == FSPS_IDLE;
  assign load_ok = spm_ok && cmd == `FSPS_CMD_LOAD;
  assign fuse_rd_ok = load_program_instruction && lpm_win_reg != 3'h0
    && ctrl_reg.fuse_lock_read_bit && ctrl_reg.store_enable_bit
    && !eeprom_write_busy_flag;
  assign op_done = state_reg != FSPS_IDLE && op_cnt_reg == 17'h1;

  always_comb
  begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    flash_next = flash_reg;
    ptr_next = ptr_reg;
    data_next = data_reg;
    spm_win_next = spm_win_reg;
    lpm_win_next = lpm_win_reg;
    op_cnt_next = op_cnt_reg;
    valid_next = valid_reg;
    lpm_next = lpm_reg;
    prdata_next = prdata_reg;
    ctrl_next.clear_buffer_bit = 1'b0;
    if (spm_win_reg != 3'h0)
      spm_win_next = spm_win_reg - 3'h1;
    if (lpm_win_reg != 3'h0)
      lpm_win_next = lpm_win_reg - 3'h1;
    // Unused command times out after four cycles
    if (state_reg == FSPS_IDLE && spm_win_reg == 3'h1 && !spm_ok)
    begin
      ctrl_next.store_enable_bit = 1'b0;
      ctrl_next.page_write_bit = 1'b0;
      ctrl_next.page_erase_bit = 1'b0;
      ctrl_next.fuse_lock_read_bit = 1'b0;
    end
    if (lpm_win_reg == 3'h1 && ctrl_reg.fuse_lock_read_bit)
    begin
      ctrl_next.fuse_lock_read_bit = 1'b0;
      ctrl_next.store_enable_bit = 1'b0;
    end
    if (load_program_instruction)
    begin
      if (fuse_rd_ok)
      begin
        lpm_next = fuse_lock_bytes[{ptr_reg[1:0], 3'b000} +: 8];
        ctrl_next.fuse_lock_read_bit = 1'b0;
        ctrl_next.store_enable_bit = 1'b0;
        lpm_win_next = 3'h0;
      end
      else if (ptr_reg[0])
        lpm_next = lpm_flash_word[15:8];
      else
        lpm_next = lpm_flash_word[7:0];
    end
    if (wr_acc && hit_ptr)
      ptr_next = pwdata[15:0];
    if (wr_acc && hit_data)
      data_next = pwdata[15:0];
    if (wr_acc && hit_ctrl && state_reg == FSPS_IDLE)
    begin
      ctrl_next = fsps_ctrl_type'(pwdata[4:0]);
      ctrl_next.clear_buffer_bit = 1'b0;
      spm_win_next = pwdata[0] ? `FSPS_SPM_WIN : 3'h0;
      lpm_win_next = pwdata[0] && pwdata[3] ? `FSPS_LPM_WIN : 3'h0;
    end
    case (state_reg)
      FSPS_IDLE:
      begin
        if (spm_ok)
        begin
          spm_win_next = 3'h0;
          ctrl_next.store_enable_bit = 1'b0;
          if (cmd == `FSPS_CMD_LOAD)
            valid_next[word_idx] = 1'b1;
          else if (cmd == `FSPS_CMD_ERASE)
          begin
            ctrl_next.store_enable_bit = 1'b1;
            state_next = FSPS_ERASE;
            flash_next = '{erase: 1'b1, write: 1'b0, page: page_idx};
            op_cnt_next = 17'(OP_CYCLES);
          end
          else if (cmd == `FSPS_CMD_WRITE)
          begin
            ctrl_next.store_enable_bit = 1'b1;
            state_next = FSPS_WRITE;
            flash_next = '{erase: 1'b0, write: 1'b1, page: page_idx};
            op_cnt_next = 17'(OP_CYCLES);
          end
          else
            ctrl_next = `FSPS_CTRL_RST;
        end
      end
      FSPS_ERASE, FSPS_WRITE:
      begin
        op_cnt_next = op_cnt_reg - 17'h1;
        if (op_done)
        begin
          state_next = FSPS_IDLE;
          ctrl_next = `FSPS_CTRL_RST;
          flash_next.erase = 1'b0;
          flash_next.write = 1'b0;
          if (state_reg == FSPS_WRITE)
            valid_next = '0;
        end
      end
      default:
        state_next = FSPS_IDLE;
    endcase
    // Discards come after the load, so a clear beats a load
    if (eeprom_write_start)
      valid_next = '0;
    if (wr_acc && hit_ctrl && pwdata[4])
      valid_next = '0;
    // Read data is latched in the setup cycle, so no wait states
    if (setup)
    begin
      if (hit_ctrl)
        prdata_next = {27'h0, ctrl_reg};
      else if (hit_ptr)
        prdata_next = {16'h0, ptr_reg};
      else if (hit_data)
        prdata_next = {16'h0, data_reg};
      else if (hit_stat)
        prdata_next = {28'h0, |valid_reg, state_reg[2:1],
          state_reg != FSPS_IDLE};
      else
        prdata_next = 32'h0;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= FSPS_IDLE;
      ctrl_reg <= `FSPS_CTRL_RST;
      flash_reg <= '0;
      ptr_reg <= 16'h0000;
      data_reg <= 16'h0000;
      spm_win_reg <= 3'h0;
      lpm_win_reg <= 3'h0;
      op_cnt_reg <= 17'h00000;
      valid_reg <= '0;
      lpm_reg <= 8'h00;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      flash_reg <= flash_next;
      ptr_reg <= ptr_next;
      data_reg <= data_next;
      spm_win_reg <= spm_win_next;
      lpm_win_reg <= lpm_win_next;
      op_cnt_reg <= op_cnt_next;
      valid_reg <= valid_next;
      lpm_reg <= lpm_next;
      prdata_reg <= prdata_next;
    end
  end

  // Buffer storage needs no reset; valid bits mark loaded words
  always_ff @(posedge core_clk)
  begin
    if (load_ok)
      buf_mem[word_idx] <= data_reg;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      buf_rd_data <= `FSPS_BLANK_WORD;
    else if (valid_reg[buf_rd_addr])
      buf_rd_data <= buf_mem[buf_rd_addr];
    else
      buf_rd_data <= `FSPS_BLANK_WORD;
  end

  assign prdata = prdata_reg;
  assign lpm_data = lpm_reg;
  assign flash_cmd = flash_reg;
  assign cpu_halt = state_reg != FSPS_IDLE;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_FUSE_GATE: assert property (
    state_reg == FSPS_IDLE && fuse_s2_reg |=> state_reg == FSPS_IDLE)
    else $error("store acted with fuse unprogrammed");
  AST_ERASE_START: assert property (
    spm_ok && cmd == `FSPS_CMD_ERASE |=> state_reg == FSPS_ERASE
      && flash_cmd.erase && cpu_halt)
    else $error("erase did not start");
  AST_ERASE_HALT: assert property (
    $rose(flash_cmd.erase) |-> cpu_halt [*8])
    else $error("cpu not halted during erase");
  AST_WRITE_HALT: assert property (
    state_reg == FSPS_WRITE |-> cpu_halt && flash_cmd.write)
    else $error("cpu not halted during write");
  AST_LOAD_MARK: assert property (
    load_ok && !eeprom_write_start && !(wr_acc && hit_ctrl && pwdata[4])
      |=> valid_reg[$past(word_idx)])
    else $error("loaded word not marked");
  AST_WRITE_CLEAR: assert property (
    op_done && state_reg == FSPS_WRITE |=> valid_reg == '0)
    else $error("buffer kept after page write");
  AST_EE_DISCARD: assert property (
    eeprom_write_start |=> valid_reg == '0)
    else $error("buffer kept after eeprom write");
  AST_EE_BLOCK: assert property (
    eeprom_write_busy_flag && state_reg == FSPS_IDLE
      |=> state_reg == FSPS_IDLE)
    else $error("programming during eeprom write");
  AST_TIMEOUT: assert property (
    state_reg == FSPS_IDLE && spm_win_reg == 3'h1 && !spm_ok
      |=> !ctrl_reg.store_enable_bit && !ctrl_reg.page_write_bit)
    else $error("command bits did not time out");
  AST_RELEASE: assert property (
    op_done |=> !cpu_halt && state_reg == FSPS_IDLE
      && ctrl_reg == `FSPS_CTRL_RST)
    else $error("halt not released after operation");
  AST_BYTE_SEL: assert property (
    load_program_instruction && !fuse_rd_ok && ptr_reg[0]
      |=> lpm_data == $past(lpm_flash_word[15:8]))
    else $error("wrong byte returned");
endmodule

// >>> tb/fsps_cpu_model.sv
// Purpose: CPU core model issuing store and load instructions
// Assumes: Tasks are entered just after a rising core_clk edge
// Notes: Flash word bus shows inverse data outside a load pulse
`timescale 1ns/10ps
module fsps_cpu_model
(
  input wire logic core_clk,
  input wire logic cpu_halt,
  output logic store_program_instruction,
  output logic load_program_instruction,
  output logic [15:0] lpm_flash_word
);
  initial
  begin
    store_program_instruction = 1'b0;
    load_program_instruction = 1'b0;
    lpm_flash_word = 16'h0000;
  end
  // A halted core fetches nothing, so it sits out the halt
  task automatic issue_store(input int gap);
    repeat (gap) @(posedge core_clk);
    while (cpu_halt === 1'b1) @(posedge core_clk);
    store_program_instruction <= 1'b1;
    @(posedge core_clk);
    store_program_instruction <= 1'b0;
  endtask
  task automatic issue_load(input logic [15:0] word);
    lpm_flash_word <= word;
    load_program_instruction <= 1'b1;
    @(posedge core_clk);
    load_program_instruction <= 1'b0;
    lpm_flash_word <= ~word;
  endtask
endmodule

// >>> tb/test_fsps_sequencer.sv
// Purpose: Self-checking bench for the flash sequencer
// Assumes: OP_CYCLES shortened to 20, 32-word page
// Notes: Page field sits above pointer bit 5
`timescale 1ns/10ps
`include "fsps_cfg.svh"
`define CHK(nm, exp, got) \
  begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module test_fsps_sequencer
  import fsps_pkg::*;
;
  localparam logic [9:0] CTRL = {`FSPS_CTRL_IDX, 2'b00};
  localparam logic [9:0] PTR = {`FSPS_PTR_IDX, 2'b00};
  localparam logic [9:0] DAT = {`FSPS_DATA_IDX, 2'b00};
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, q, fuse_bytes;
  logic store_i, load_i, fuse_n, ee_busy, ee_start, cpu_halt;
  logic [15:0] flash_word, buf_rd_data;
  logic [7:0] lpm_data;
  logic [4:0] buf_rd_addr;
  fsps_flash_type flash_cmd;
  int failures = 0, n_tests = 0, cyc = 0, n;
  logic seen, err;
  fsps_sequencer #(.WORD_BITS(5), .OP_CYCLES(20)) fsps_sequencer_i (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .store_program_instruction(store_i),
    .load_program_instruction(load_i), .lpm_flash_word(flash_word),
    .fuse_lock_bytes(fuse_bytes), .lpm_data(lpm_data),
    .self_program_fuse_n(fuse_n), .eeprom_write_busy_flag(ee_busy),
    .eeprom_write_start(ee_start), .cpu_halt(cpu_halt),
    .flash_cmd(flash_cmd), .buf_rd_addr(buf_rd_addr),
    .buf_rd_data(buf_rd_data));
  fsps_cpu_model fsps_cpu_model_i (.core_clk(core_clk),
    .cpu_halt(cpu_halt), .store_program_instruction(store_i),
    .load_program_instruction(load_i), .lpm_flash_word(flash_word));
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Bounded by the timeout counter, not by an assumed latency
  task automatic apb(input logic wr, input logic [9:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic load_word(input logic [15:0] p, input logic [15:0] d);
    apb(1'b1, PTR, {16'h0000, p});
    apb(1'b1, DAT, {16'h0000, d});
    apb(1'b1, CTRL, 32'h0000_0001);
    fsps_cpu_model_i.issue_store(0);
  endtask
  task automatic check_buf(input logic [4:0] a, input logic [15:0] e);
    buf_rd_addr <= a;
    @(posedge core_clk);
    #1 `CHK("buffer word", e, buf_rd_data)
    @(posedge core_clk);
  endtask
  // Counts halted cycles; seen notes the matching flash command
  task automatic run_op(input logic [31:0] code);
    apb(1'b1, PTR, 32'h0000_0040);
    while (ee_busy === 1'b1) @(posedge core_clk);
    apb(1'b1, CTRL, code);
    fsps_cpu_model_i.issue_store(0);
    n = 0;
    seen = 1'b0;
    repeat (40)
    begin
      #1 if (cpu_halt === 1'b1)
      begin
        n++;
        seen |= code[2] ? flash_cmd.write : flash_cmd.erase;
      end
      @(posedge core_clk);
    end
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      final_report();
    end
  end
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, ee_busy, ee_start} = 5'h00;
    paddr = 10'h000;
    pwdata = 32'h0000_0000;
    fuse_n = 1'b1;
    buf_rd_addr = 5'h00;
    fuse_bytes = 32'h3C5A_96F0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0000_0000, q)
    apb(1'b0, 10'h3FC, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    load_word(16'h0000, 16'h1111);
    check_buf(5'h00, 16'hFFFF);
    fuse_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    apb(1'b1, CTRL, 32'h0000_0003);
    fsps_cpu_model_i.issue_store(5);
    apb(1'b0, CTRL, 32'h0);
    `CHK("late store halt", 1'b0, cpu_halt)
    `CHK("cmd bits cleared", 32'h0, q & 32'h6)
    run_op(32'h0000_0003);
    `CHK("erase halt cycles", 20, n)
    `CHK("erase command", 1'b1, seen)
    `CHK("flash page", 16'h0001, flash_cmd.page)
    apb(1'b0, CTRL, 32'h0);
    `CHK("erase bits clear", 32'h0, q & 32'h6)
    load_word(16'h0046, 16'h1234);
    load_word(16'h0042, 16'hBEEF);
    check_buf(5'h03, 16'h1234);
    check_buf(5'h01, 16'hBEEF);
    check_buf(5'h02, 16'hFFFF);
    run_op(32'h0000_0005);
    `CHK("write halt cycles", 20, n)
    `CHK("write command", 1'b1, seen)
    check_buf(5'h03, 16'hFFFF);
    load_word(16'h0044, 16'h2222);
    apb(1'b1, CTRL, 32'h0000_0010);
    check_buf(5'h02, 16'hFFFF);
    load_word(16'h0048, 16'h4444);
    ee_start <= 1'b1;
    @(posedge core_clk);
    ee_start <= 1'b0;
    check_buf(5'h04, 16'hFFFF);
    ee_busy <= 1'b1;
    load_word(16'h004A, 16'h5555);
    check_buf(5'h05, 16'hFFFF);
    ee_busy <= 1'b0;
    apb(1'b1, PTR, 32'h0000_0001);
    fsps_cpu_model_i.issue_load(16'hA55A);
    #1 `CHK("high byte", 8'hA5, lpm_data)
    @(posedge core_clk);
    apb(1'b1, PTR, 32'h0000_0000);
    fsps_cpu_model_i.issue_load(16'hA55A);
    #1 `CHK("low byte", 8'h5A, lpm_data)
    @(posedge core_clk);
    apb(1'b1, PTR, 32'h0000_0001);
    apb(1'b1, CTRL, 32'h0000_0009);
    fsps_cpu_model_i.issue_load(16'hA55A);
    #1 `CHK("fuse byte", 8'h96, lpm_data)
    @(posedge core_clk);
    ee_busy <= 1'b1;
    apb(1'b1, CTRL, 32'h0000_0009);
    fsps_cpu_model_i.issue_load(16'hA55A);
    #1 `CHK("fuse read blocked", 8'hA5, lpm_data)
    final_report();
  end
endmodule
